// ---- include/fsss_cfg.svh ----
// timing constants and pin-vector positions of the four switch state sequencer
// assumes a single 125 MHz core clock; included by bare name
`ifndef FSSS_CFG_SVH
`define FSSS_CFG_SVH

// clock and times, ns
`define FSSS_CLK_NS 8
`define FSSS_TSW_NS 2000
`define FSSS_TMIN_NS 200
`define FSSS_DEAD_NS 24
`define FSSS_INIT_NS 1000

// derived cycle counts: period rounds down, minimum, dead and init times round up
`define FSSS_PERIOD_CYC (`FSSS_TSW_NS / `FSSS_CLK_NS)
`define FSSS_TMIN_CYC ((`FSSS_TMIN_NS + `FSSS_CLK_NS - 1) / `FSSS_CLK_NS)
`define FSSS_DEAD_CYC ((`FSSS_DEAD_NS + `FSSS_CLK_NS - 1) / `FSSS_CLK_NS)
`define FSSS_INIT_CYC ((`FSSS_INIT_NS + `FSSS_CLK_NS - 1) / `FSSS_CLK_NS)

// output level code: 0 at or below nominal, full scale one percent above
`define FSSS_LVL_W 4
// lfsr for the random entry level
`define FSSS_LFSR_SEED 8'h5a
`define FSSS_LFSR_TAPS 8'hb8

// bit positions in the synchronised pin vector
`define FSSS_PIN_W 16
`define FSSS_B_MODE 0
`define FSSS_B_PEAK 1
`define FSSS_B_TON 2
`define FSSS_B_TOFF 3
`define FSSS_B_DLIM 4
`define FSSS_B_LOWI 5
`define FSSS_B_DEM 6
`define FSSS_B_VHI 7
`define FSSS_B_EN 8
`define FSSS_B_VOK 9
`define FSSS_B_FLT 10
`define FSSS_B_POR 11
`define FSSS_B_LVL 12

`endif

// ---- include/fsss_pkg.sv ----
// types of the four switch state sequencer
// assumes nothing beyond a SystemVerilog compiler
package fsss_pkg;
	// active switching states seen by the bridges
	typedef enum logic [2:0] {
		FSSS_SW_OFF = 3'b000,
		FSSS_SW_ONE = 3'b001,
		FSSS_SW_TWO = 3'b010,
		FSSS_SW_THREE = 3'b011,
		FSSS_SW_SLEEP = 3'b100
	} fsss_sw_t;
	// conversion mode
	typedef enum logic [1:0] {
		FSSS_MD_BUCK = 2'b00,
		FSSS_MD_BOOST = 2'b01,
		FSSS_MD_BB = 2'b10
	} fsss_mode_t;
endpackage

// ---- rtl/fsss_sync.sv ----
// three flop pin synchroniser with agreement filter
// assumes asynchronous pins; reset value zero for every bit
`timescale 1ns/10ps
`default_nettype none
module fsss_sync #(
	parameter int WIDTH = 1
) (
	// clock and reset
	input wire logic mclk_in,
	input wire logic rst_b_in,
	// pins and filtered result
	input wire logic [WIDTH-1:0] pin_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] s1_r;
	logic [WIDTH-1:0] s2_r;
	logic [WIDTH-1:0] s3_r;
	logic [WIDTH-1:0] q_nxt;

	// a bit changes only when second and third stages agree
	assign q_nxt = (s2_r & s3_r) | (sync_out & (s2_r | s3_r));

	// shift chain and filtered output
	always_ff @(posedge mclk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			s1_r <= '0;
			s2_r <= '0;
			s3_r <= '0;
			sync_out <= '0;
		end
		else
		begin
			s1_r <= pin_in;
			s2_r <= s1_r;
			s3_r <= s2_r;
			sync_out <= q_nxt;
		end
	end
endmodule // fsss_sync
`default_nettype wire

// ---- rtl/fsss_sequencer.sv ----
// four switch buck-boost switching state sequencer
// assumes pins from the analog loop are asynchronous; gate drivers follow
// the switch outputs directly
`include "fsss_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
module fsss_sequencer (
	// clock and reset
	input wire logic mclk_in,
	input wire logic rst_b_in,
	// supervision pins
	input wire logic por_ok_in,
	input wire logic enable_undervoltage_pin_in,
	input wire logic input_supply_pin_ok_in,
	input wire logic output_fault_in,
	// mode select, low enables power save
	input wire logic light_load_save_mode_in,
	// loop comparators
	input wire logic peak_cur_in,
	input wire logic buck_ton_over_in,
	input wire logic boost_toff_over_in,
	input wire logic duty_limit_in,
	input wire logic low_current_in,
	input wire logic loop_demand_in,
	input wire logic vin_above_vout_in,
	input wire logic [`FSSS_LVL_W-1:0] vout_level_in,
	// switch gates
	output logic input_high_switch_out,
	output logic input_low_switch_out,
	output logic output_high_switch_out,
	output logic output_low_switch_out,
	// status
	output fsss_pkg::fsss_mode_t conv_mode_out,
	output logic sleep_out,
	output logic fault_out_n_out,
	output logic fault_out_n_oe_out
);
	import fsss_pkg::*;

	logic [`FSSS_PIN_W-1:0] pins;
	logic [`FSSS_PIN_W-1:0] pin_s;
	logic [7:0] per_cnt_r;
	logic tick_r;
	logic [7:0] init_cnt_r;
	logic init_done_r;
	logic run;
	logic light_load_save_mode;
	logic [`FSSS_LVL_W-1:0] lvl;
	logic [`FSSS_LVL_W-1:0] entry_lvl;
	logic [7:0] lfsr_r;
	logic sleep_go;
	fsss_sw_t sw_r;
	fsss_mode_t mode_r;
	logic [7:0] cnt_r;
	logic peak_seen_r;
	logic mpulse_r;
	logic [1:0] want_hi;
	logic [1:0] want_lo;
	logic [1:0] hi_r;
	logic [1:0] lo_r;

	// all pins pass the three flop filter
	assign pins = {vout_level_in, por_ok_in, output_fault_in,
		input_supply_pin_ok_in, enable_undervoltage_pin_in, vin_above_vout_in,
		loop_demand_in, low_current_in, duty_limit_in, boost_toff_over_in,
		buck_ton_over_in, peak_cur_in, light_load_save_mode_in};

	fsss_sync #(
		.WIDTH(`FSSS_PIN_W)
	) u_sync (
		.mclk_in(mclk_in),
		.rst_b_in(rst_b_in),
		.pin_in(pins),
		.sync_out(pin_s)
	);

	// run gate and power save select
	assign run = init_done_r && pin_s[`FSSS_B_EN]
		&& pin_s[`FSSS_B_VOK];
	assign light_load_save_mode = !pin_s[`FSSS_B_MODE];
	assign lvl = pin_s[`FSSS_B_LVL +: `FSSS_LVL_W];

	// free running period divider, same period in every mode
	always_ff @(posedge mclk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			per_cnt_r <= 8'h00;
			tick_r <= 1'b0;
		end
		else if (per_cnt_r == 8'(`FSSS_PERIOD_CYC - 1))
		begin
			per_cnt_r <= 8'h00;
			tick_r <= 1'b1;
		end
		else
		begin
			per_cnt_r <= per_cnt_r + 8'h01;
			tick_r <= 1'b0;
		end
	end

	// initialization after supply good, restarted on supply loss
	always_ff @(posedge mclk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			init_cnt_r <= 8'h00;
			init_done_r <= 1'b0;
		end
		else if (!pin_s[`FSSS_B_POR])
		begin
			init_cnt_r <= 8'h00;
			init_done_r <= 1'b0;
		end
		else if (init_cnt_r == 8'(`FSSS_INIT_CYC - 1))
			init_done_r <= 1'b1;
		else
			init_cnt_r <= init_cnt_r + 8'h01;
	end

	// random sleep entry level, never at nominal itself
	always_ff @(posedge mclk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
			lfsr_r <= `FSSS_LFSR_SEED;
		else if (tick_r)
			lfsr_r <= {1'b0, lfsr_r[7:1]} ^ (lfsr_r[0] ? `FSSS_LFSR_TAPS : 8'h00);
	end
	assign entry_lvl = (lfsr_r[`FSSS_LVL_W-1:0] == '0) ? `FSSS_LVL_W'(1)
		: lfsr_r[`FSSS_LVL_W-1:0];

	// sleep entry: timing limit, low current, output at or above random level
	assign sleep_go = light_load_save_mode && pin_s[`FSSS_B_DLIM] && pin_s[`FSSS_B_LOWI]
		&& (lvl >= entry_lvl);

	// conversion mode, updated at cycle start; while not running it follows vin above vout every cycle
	always_ff @(posedge mclk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
			mode_r <= FSSS_MD_BUCK;
		else if (!run)
			mode_r <= pin_s[`FSSS_B_VHI] ? FSSS_MD_BUCK : FSSS_MD_BOOST;
		else if (tick_r)
		begin
			unique case (mode_r)
				FSSS_MD_BUCK:
					if (pin_s[`FSSS_B_TON] || pin_s[`FSSS_B_DLIM])
						mode_r <= FSSS_MD_BB;
				FSSS_MD_BOOST:
					if (pin_s[`FSSS_B_TOFF])
						mode_r <= FSSS_MD_BB;
				FSSS_MD_BB:
					if (pin_s[`FSSS_B_VHI] && !pin_s[`FSSS_B_TON])
						mode_r <= FSSS_MD_BUCK;
					else if (!pin_s[`FSSS_B_VHI] && !pin_s[`FSSS_B_TOFF])
						mode_r <= FSSS_MD_BOOST;
				default:
					mode_r <= FSSS_MD_BUCK;
			endcase
		end
	end

	// switching state machine
	always_ff @(posedge mclk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			sw_r <= FSSS_SW_OFF;
			cnt_r <= 8'h00;
			peak_seen_r <= 1'b0;
			mpulse_r <= 1'b0;
		end
		else if (!run)
		begin
			sw_r <= FSSS_SW_OFF;
			mpulse_r <= 1'b0;
		end
		else if (sw_r == FSSS_SW_SLEEP)
		begin
			if (lvl == '0 || !light_load_save_mode)
				sw_r <= FSSS_SW_OFF;
		end
		else if (sleep_go)
			sw_r <= FSSS_SW_SLEEP;
		else if (tick_r)
		begin
			cnt_r <= 8'(`FSSS_TMIN_CYC);
			peak_seen_r <= 1'b0;
			mpulse_r <= 1'b0;
			unique case (mode_r)
				FSSS_MD_BOOST:
					sw_r <= FSSS_SW_ONE;
				FSSS_MD_BUCK:
					sw_r <= FSSS_SW_TWO;
				default:
				begin
					if (light_load_save_mode && !pin_s[`FSSS_B_DEM])
						sw_r <= FSSS_SW_OFF;
					else if (light_load_save_mode)
					begin
						mpulse_r <= 1'b1;
						sw_r <= pin_s[`FSSS_B_VHI] ? FSSS_SW_THREE : FSSS_SW_ONE;
					end
					else
						sw_r <= FSSS_SW_ONE;
				end
			endcase
		end
		else
		begin
			if (cnt_r != 8'h00)
				cnt_r <= cnt_r - 8'h01;
			unique case (sw_r)
				FSSS_SW_ONE:
					if (cnt_r == 8'h00)
					begin
						peak_seen_r <= pin_s[`FSSS_B_PEAK];
						cnt_r <= 8'(`FSSS_TMIN_CYC);
						sw_r <= mpulse_r ? FSSS_SW_OFF : FSSS_SW_TWO;
					end
				FSSS_SW_TWO:
					if (mode_r == FSSS_MD_BUCK && pin_s[`FSSS_B_PEAK])
						sw_r <= FSSS_SW_THREE;
					else if (mode_r == FSSS_MD_BB && cnt_r == 8'h00
						&& (pin_s[`FSSS_B_PEAK] || peak_seen_r))
						sw_r <= FSSS_SW_THREE;
				FSSS_SW_THREE:
					if (mpulse_r && cnt_r == 8'h00)
						sw_r <= FSSS_SW_OFF;
				default:
					sw_r <= sw_r;
			endcase
		end
	end

	// wanted gates per bridge: index 0 input bridge, 1 output bridge
	always_comb
	begin
		want_hi = 2'b00;
		want_lo = 2'b00;
		unique case (sw_r)
			FSSS_SW_ONE:
			begin
				want_hi = 2'b01;
				want_lo = 2'b10;
			end
			FSSS_SW_TWO:
				want_hi = 2'b11;
			FSSS_SW_THREE:
			begin
				want_hi = 2'b10;
				want_lo = 2'b01;
			end
			FSSS_SW_SLEEP:
				want_lo = 2'b11;
			default:
				want_hi = 2'b00;
		endcase
	end

	// per bridge break before make with dead time
	for (genvar b = 0; b < 2; b++)
	begin : g_bridge
		logic [7:0] dcnt_r;
		always_ff @(posedge mclk_in or negedge rst_b_in)
		begin
			if (!rst_b_in)
			begin
				hi_r[b] <= 1'b0;
				lo_r[b] <= 1'b0;
				dcnt_r <= 8'h00;
			end
			else if ((hi_r[b] && !want_hi[b]) || (lo_r[b] && !want_lo[b]))
			begin
				hi_r[b] <= 1'b0;
				lo_r[b] <= 1'b0;
				dcnt_r <= 8'(`FSSS_DEAD_CYC);
			end
			else if (dcnt_r != 8'h00)
				dcnt_r <= dcnt_r - 8'h01;
			else
			begin
				hi_r[b] <= want_hi[b];
				lo_r[b] <= want_lo[b] && !want_hi[b];
			end
		end
	end

	assign input_high_switch_out = hi_r[0];
	assign input_low_switch_out = lo_r[0];
	assign output_high_switch_out = hi_r[1];
	assign output_low_switch_out = lo_r[1];

	// status flops
	always_ff @(posedge mclk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			conv_mode_out <= FSSS_MD_BUCK;
			sleep_out <= 1'b0;
			fault_out_n_out <= 1'b0;
			fault_out_n_oe_out <= 1'b0;
		end
		else
		begin
			conv_mode_out <= mode_r;
			sleep_out <= (sw_r == FSSS_SW_SLEEP);
			fault_out_n_out <= 1'b0;
			fault_out_n_oe_out <= pin_s[`FSSS_B_FLT];
		end
	end

	// checks
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (!rst_b_in);

	// gates settle two cycles plus dead time after a state change
	sequence s_one_held;
		(sw_r == FSSS_SW_ONE)[*6];
	endsequence
	sequence s_two_held;
		(sw_r == FSSS_SW_TWO)[*6];
	endsequence
	sequence s_three_held;
		(sw_r == FSSS_SW_THREE)[*6];
	endsequence

	AST_NO_SHOOT: assert property (!(hi_r[0] && lo_r[0]) && !(hi_r[1] && lo_r[1]))
		else $error("both switches of a bridge on");
	AST_DEAD_GAP: assert property ($fell(lo_r[0]) |-> !hi_r[0] [*3])
		else $error("input bridge dead time too short");
	AST_STATE_ONE: assert property (s_one_held |-> hi_r == 2'b01 && lo_r == 2'b10)
		else $error("state one gates wrong");
	AST_STATE_TWO: assert property (s_two_held |-> hi_r == 2'b11 && lo_r == 2'b00)
		else $error("state two gates wrong");
	AST_STATE_THREE: assert property (s_three_held |-> hi_r == 2'b10 && lo_r == 2'b01)
		else $error("state three gates wrong");
	AST_PERIOD: assert property (tick_r |-> ##250 tick_r)
		else $error("switching period drifted");
	AST_BUCK_START: assert property (tick_r && run && mode_r == FSSS_MD_BUCK
		&& sw_r != FSSS_SW_SLEEP && !sleep_go |=> sw_r == FSSS_SW_TWO)
		else $error("buck cycle not started in state two");
	AST_BUCK_PEAK: assert property (run && !tick_r && !sleep_go && mode_r == FSSS_MD_BUCK
		&& sw_r == FSSS_SW_TWO && pin_s[`FSSS_B_PEAK] |=> sw_r == FSSS_SW_THREE)
		else $error("buck peak did not end state two");
	AST_VIN_BLOCK: assert property (!pin_s[`FSSS_B_VOK] [*2] |-> ##[0:2] hi_r == 2'b00)
		else $error("switching while input supply low");
	AST_SLEEP_LOWS: assert property ((sw_r == FSSS_SW_SLEEP)[*6] |-> lo_r == 2'b11)
		else $error("low switches not on in sleep");
	AST_NO_PSM: assert property (pin_s[`FSSS_B_MODE] |=> sw_r != FSSS_SW_SLEEP)
		else $error("sleep with power save off");
	AST_FAULT: assert property (pin_s[`FSSS_B_FLT] |=> fault_out_n_oe_out)
		else $error("fault not signalled");
endmodule // fsss_sequencer
`default_nettype wire

// ---- verification/fsss_bridge_model.sv ----
// behavioural power bridge: inductor ramp, peak comparator, leg monitor
// assumes the sequencer gate outputs and the same core clock
`timescale 1ns/10ps
`default_nettype none
module fsss_bridge_model #(
	parameter int PEAK_CYC = 100
) (
	// clock and reset
	input wire logic mclk_in,
	input wire logic rst_b_in,
	// gates from the sequencer
	input wire logic input_high_switch_in,
	input wire logic input_low_switch_in,
	input wire logic output_high_switch_in,
	input wire logic output_low_switch_in,
	// comparator and monitor
	output logic peak_cur_out,
	output logic shoot_out
);
	int ramp_r;
	// current ramps while the input high switch conducts, clears to zero otherwise
	always_ff @(posedge mclk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
			ramp_r <= 0;
		else if (input_high_switch_in)
			ramp_r <= ramp_r + 1;
		else
			ramp_r <= 0;
	end
	// comparator trips after a fixed ramp, no hysteresis
	assign peak_cur_out = (ramp_r >= PEAK_CYC);
	// both switches of one leg on would short the supply
	assign shoot_out = (input_high_switch_in & input_low_switch_in) |
		(output_high_switch_in & output_low_switch_in);
endmodule // fsss_bridge_model
`default_nettype wire

// ---- verification/testbench.sv ----
// self-checking bench of the switching state sequencer
// assumes the bridge model as far side; 125 MHz core clock
`timescale 1ns/10ps
`default_nettype none
module testbench;
	import fsss_pkg::*;
	logic mclk_in, rst_b_in, por, en, sup_ok, flt, save_n, peak, ton, toff;
	logic dlim, lowi, dem, vhi, ih, il, oh, ol, slp, fn, foe, shoot;
	logic [3:0] lvl;
	fsss_mode_t md;
	wire logic [3:0] gates = {ih, il, oh, ol};
	int fails, n_tests, cyc, t0, t1, t2;
	fsss_sequencer uut (.mclk_in(mclk_in), .rst_b_in(rst_b_in), .por_ok_in(por),
		.enable_undervoltage_pin_in(en), .input_supply_pin_ok_in(sup_ok),
		.output_fault_in(flt), .light_load_save_mode_in(save_n), .peak_cur_in(peak),
		.buck_ton_over_in(ton), .boost_toff_over_in(toff), .duty_limit_in(dlim),
		.low_current_in(lowi), .loop_demand_in(dem), .vin_above_vout_in(vhi),
		.vout_level_in(lvl), .input_high_switch_out(ih), .input_low_switch_out(il),
		.output_high_switch_out(oh), .output_low_switch_out(ol), .conv_mode_out(md),
		.sleep_out(slp), .fault_out_n_out(fn), .fault_out_n_oe_out(foe));
	fsss_bridge_model bridge (.mclk_in(mclk_in), .rst_b_in(rst_b_in),
		.input_high_switch_in(ih), .input_low_switch_in(il),
		.output_high_switch_in(oh), .output_low_switch_in(ol),
		.peak_cur_out(peak), .shoot_out(shoot));
	// clock
	initial
	begin
		mclk_in = 1'b0;
		forever #4 mclk_in = ~mclk_in;
	end
	// cycle count and leg monitor
	always @(posedge mclk_in)
	begin
		cyc <= cyc + 1;
		if (shoot === 1'b1) check(shoot, 1'b0);
	end
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			fails++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// wait for a gate to rise, bounded; returns the cycle of the rise
	task automatic wait_rise(input int idx, output int at);
		int n;
		n = 0;
		while (gates[idx] === 1'b1 && n < 1000)
		begin
			@(posedge mclk_in);
			#1;
			n++;
		end
		while (gates[idx] !== 1'b1 && n < 1000)
		begin
			@(posedge mclk_in);
			#1;
			n++;
		end
		if (n >= 1000) check(n, 0);
		at = cyc;
	endtask
	task automatic wait_mode(input fsss_mode_t m);
		int n;
		for (n = 0; n < 1000 && md !== m; n++)
		begin
			@(posedge mclk_in);
			#1;
		end
		check(md, m);
	endtask
	task automatic t_reset;
		check({gates, slp, foe}, 6'h00);
		check(md, FSSS_MD_BUCK);
	endtask
	task automatic t_buck;
		wait_rise(3, t0);
		check(gates, 4'b1010);
		wait_rise(2, t0);
		check(gates, 4'b0110);
		wait_rise(3, t1);
		wait_rise(3, t2);
		check(t2 - t1, 250);
	endtask
	task automatic t_bb;
		@(posedge mclk_in) ton <= 1'b1;
		wait_mode(FSSS_MD_BB);
		wait_rise(0, t0);
		check(gates, 4'b1001);
		wait_rise(1, t0);
		check(gates, 4'b1010);
		wait_rise(2, t0);
		check(gates, 4'b0110);
	endtask
	task automatic t_boost;
		@(posedge mclk_in);
		vhi <= 1'b0;
		ton <= 1'b0;
		wait_mode(FSSS_MD_BOOST);
		wait_rise(0, t1);
		check(gates, 4'b1001);
		wait_rise(1, t2);
		check(gates, 4'b1010);
		check((t2 - t1 >= 25) && (t2 - t1 <= 26), 1'b1);
	endtask
	task automatic t_save;
		int hits;
		hits = 0;
		@(posedge mclk_in);
		dlim <= 1'b1;
		lowi <= 1'b1;
		save_n <= 1'b0;
		repeat (600) @(posedge mclk_in) hits += (slp === 1'b1);
		check(hits, 0);
		@(posedge mclk_in);
		save_n <= 1'b1;
		lvl <= 4'hf;
		hits = 0;
		repeat (600) @(posedge mclk_in) hits += (slp === 1'b1);
		check(hits, 0);
		@(posedge mclk_in) save_n <= 1'b0;
		for (hits = 0; hits < 1000 && slp !== 1'b1; hits++)
			@(posedge mclk_in);
		check(slp, 1'b1);
		repeat (10) @(posedge mclk_in);
		#1;
		check(gates, 4'b0101);
		@(posedge mclk_in) lvl <= 4'h0;
		repeat (12) @(posedge mclk_in);
		#1;
		check(slp, 1'b0);
		@(posedge mclk_in);
		save_n <= 1'b1;
		dlim <= 1'b0;
		lowi <= 1'b0;
		wait_rise(0, t0);
	endtask
	task automatic t_supply;
		@(posedge mclk_in) sup_ok <= 1'b0;
		repeat (10) @(posedge mclk_in);
		#1;
		check(gates, 4'b0000);
		repeat (300) @(posedge mclk_in);
		check(gates, 4'b0000);
		@(posedge mclk_in) sup_ok <= 1'b1;
		wait_rise(0, t0);
		@(posedge mclk_in) en <= 1'b0;
		repeat (10) @(posedge mclk_in);
		#1;
		check(gates, 4'b0000);
		@(posedge mclk_in) en <= 1'b1;
	endtask
	task automatic t_fault;
		@(posedge mclk_in) flt <= 1'b1;
		repeat (8) @(posedge mclk_in);
		#1;
		check({foe, fn}, 2'b10);
		@(posedge mclk_in) flt <= 1'b0;
		repeat (8) @(posedge mclk_in);
		#1;
		check(foe, 1'b0);
	endtask
	// power save in buck-boost: skipped cycles and minimum pulses
	task automatic t_psm;
		@(posedge mclk_in);
		save_n <= 1'b0;
		toff <= 1'b1;
		wait_mode(FSSS_MD_BB);
		repeat (260) @(posedge mclk_in);
		#1;
		check(gates, 4'b0000);
		@(posedge mclk_in) dem <= 1'b1;
		wait_rise(0, t1);
		check(gates, 4'b1001);
		repeat (30) @(posedge mclk_in);
		#1;
		check(gates, 4'b0000);
		@(posedge mclk_in);
		vhi <= 1'b1;
		ton <= 1'b1;
		wait_rise(2, t1);
		check(gates, 4'b0110);
		repeat (30) @(posedge mclk_in);
		#1;
		check(gates, 4'b0000);
		@(posedge mclk_in);
		save_n <= 1'b1;
		dem <= 1'b0;
		toff <= 1'b0;
		ton <= 1'b0;
	endtask
	task automatic print_verdict;
		$display("comparisons %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// watchdog against a hang
	initial
	begin
		repeat (30000) @(posedge mclk_in);
		fails++;
		print_verdict();
	end
	// main sequence
	initial
	begin
		{fails, n_tests, cyc} = '0;
		{rst_b_in, flt, ton, toff, dlim, lowi, dem} = '0;
		{por, en, sup_ok, save_n, vhi} = '1;
		lvl = 4'h0;
		repeat (10) @(posedge mclk_in);
		#1;
		t_reset();
		@(posedge mclk_in) rst_b_in <= 1'b1;
		t_buck();
		t_bb();
		t_boost();
		t_save();
		t_supply();
		t_fault();
		t_psm();
		print_verdict();
	end
endmodule // testbench
`default_nettype wire
